// file: dual_uart_modem_pin_control.sv
// Modem pin control for channel B and port pin control for both channels of a dual UART
//
// What this block does
// - Port bit one: irq driven, port pin low
// - Port bit zero: irq tristated, port pin high
// - Style select high: separate read/write strobes
// - Style select low: direction plus chip select
// - Status inputs never affect UART operation
// - RTS/DTR active low, usable as outputs
// - CTS active low, usable as input
// - Reset polarity follows the style select
`timescale 1ns/1ps
module dual_uart_modem_pin_control (
    input  wire logic       CLOCK,
    input  wire logic       SYS_RST,
    input  wire logic       BUS_STYLE,
    input  wire logic       DEV_RESET_PIN,
    input  wire logic       CS_N,
    input  wire logic       CHAN_SEL,
    input  wire logic       WR_STROBE_N,
    input  wire logic       RW_DIR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       CHA_IRQ_REQ,
    input  wire logic       CHB_IRQ_REQ,
    input  wire logic       CHB_SERIAL_TX,
    input  wire logic       CHB_SERIAL_IN,
    input  wire logic       CHB_CLEAR_SEND_N,
    input  wire logic       CHB_SET_READY_N,
    input  wire logic       CHB_CARRIER_N,
    input  wire logic       CHB_RING_N,
    output logic            CHB_SERIAL_OUT,
    output logic            CHB_SERIAL_RX,
    output logic            CHB_REQUEST_SEND_N,
    output logic            CHB_TERMINAL_READY_N,
    output logic [3:0]      CHB_MODEM_STATUS,
    output logic            CHA_IRQ_OUT,
    output logic            CHA_IRQ_OE,
    output logic            CHB_IRQ_OUT,
    output logic            CHB_IRQ_OE,
    output logic            CHA_PORT_OUT_N,
    output logic            CHB_PORT_OUT_N,
    output logic            DEV_RESET
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    uart_pin_pkg::pin_sync_t    sync1_d;
    uart_pin_pkg::pin_sync_t    sync1_q;
    uart_pin_pkg::pin_sync_t    sync2_d;
    uart_pin_pkg::pin_sync_t    sync2_q;

    // Raw pin word; the second stage only ever reads the first
    always_comb begin
        sync1_d.style   = BUS_STYLE;
        sync1_d.rst_pin = DEV_RESET_PIN;
        sync1_d.cs_n    = CS_N;
        sync1_d.wr_n    = WR_STROBE_N;
        sync1_d.rw      = RW_DIR;
        sync1_d.chan_b  = CHAN_SEL;
        sync1_d.rx      = CHB_SERIAL_IN;
        sync1_d.modem   = {CHB_CLEAR_SEND_N, CHB_SET_READY_N, CHB_CARRIER_N, CHB_RING_N};
        sync1_d.data    = WR_DATA;
        sync2_d         = sync1_q;
    end

    // Two flops on every pin from outside the clock domain
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_q <= uart_pin_pkg::PIN_SYNC_RESET;
            sync2_q <= uart_pin_pkg::PIN_SYNC_RESET;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ----------------------------------------
    // Host bus style decode and reset sense
    // ----------------------------------------
    uart_pin_pkg::bus_style_t   bus_style;
    uart_pin_pkg::host_wr_t     host_wr;
    logic                       wr_level;
    logic                       wr_start;
    logic                       wr_seen_d;
    logic                       wr_seen_q;
    logic                       wr_pend_d;
    logic                       wr_pend_q;
    logic                       dev_reset_d;
    logic                       dev_reset_q;

    // Write seen once per strobe; data taken one cycle later
    // Waiting a cycle lets every data bit settle past its synchroniser,
    // since the host holds the data word for the whole strobe
    always_comb begin
        if (sync2_q.style == uart_pin_pkg::STYLE_STROBES)
            bus_style = uart_pin_pkg::BUS_STROBES;
        else
            bus_style = uart_pin_pkg::BUS_DIR_CS;
        case (bus_style)
            uart_pin_pkg::BUS_STROBES: begin
                wr_level = !sync2_q.cs_n && !sync2_q.wr_n;
            end
            uart_pin_pkg::BUS_DIR_CS: begin
                wr_level = !sync2_q.cs_n && !sync2_q.rw;
            end
            default: begin
                wr_level = 1'h0;
            end
        endcase
        wr_start       = wr_level && !wr_seen_q;
        wr_seen_d      = wr_level;
        wr_pend_d      = wr_start;
        host_wr.wr     = wr_pend_q;
        host_wr.chan_b = sync2_q.chan_b;
        host_wr.data   = sync2_q.data;
        if (bus_style == uart_pin_pkg::BUS_STROBES)
            dev_reset_d = sync2_q.rst_pin;
        else
            dev_reset_d = !sync2_q.rst_pin;
    end

    // Edge memory starts low, matching the idle strobe: no false write
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_seen_q   <= uart_pin_pkg::PIN_LOW;
            wr_pend_q   <= uart_pin_pkg::PIN_LOW;
            dev_reset_q <= uart_pin_pkg::PIN_LOW;
        end else begin
            wr_seen_q   <= wr_seen_d;
            wr_pend_q   <= wr_pend_d;
            dev_reset_q <= dev_reset_d;
        end
    end

    // ----------------------------------------
    // Modem control registers, one per channel
    // ----------------------------------------
    logic [7:0]                 mcr_a_d;
    logic [7:0]                 mcr_a_q;
    logic [7:0]                 mcr_b_d;
    logic [7:0]                 mcr_b_q;

    // Device reset wins over a write in the same cycle
    always_comb begin
        mcr_a_d = mcr_a_q;
        mcr_b_d = mcr_b_q;
        if (dev_reset_q) begin
            mcr_a_d = uart_pin_pkg::MCR_RESET;
            mcr_b_d = uart_pin_pkg::MCR_RESET;
        end else if (host_wr.wr) begin
            if (host_wr.chan_b)
                mcr_b_d = host_wr.data;
            else
                mcr_a_d = host_wr.data;
        end
    end

    // Register the control words
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mcr_a_q <= uart_pin_pkg::MCR_RESET;
            mcr_b_q <= uart_pin_pkg::MCR_RESET;
        end else begin
            mcr_a_q <= mcr_a_d;
            mcr_b_q <= mcr_b_d;
        end
    end

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    uart_pin_pkg::chan_pin_t    pins_a_d;
    uart_pin_pkg::chan_pin_t    pins_a_q;
    uart_pin_pkg::chan_pin_t    pins_b_d;
    uart_pin_pkg::chan_pin_t    pins_b_q;
    uart_pin_pkg::modem_in_t    status_d;
    uart_pin_pkg::modem_in_t    status_q;
    logic                       irq_a_d;
    logic                       irq_a_q;
    logic                       irq_b_d;
    logic                       irq_b_q;
    logic                       tx_d;
    logic                       tx_q;
    logic                       rx_d;
    logic                       rx_q;
    logic                       rts_n_d;
    logic                       rts_n_q;
    logic                       dtr_n_d;
    logic                       dtr_n_q;

    // Port pin and interrupt enable both follow one control bit
    function automatic uart_pin_pkg::chan_pin_t chan_pins(input logic [7:0] ctrl);
        chan_pins.port_n = !ctrl[uart_pin_pkg::PORT_BIT_POS];
        chan_pins.irq_oe = ctrl[uart_pin_pkg::PORT_BIT_POS];
    endfunction : chan_pins

    // Outputs built from next values so pins move with the registers
    always_comb begin
        pins_a_d = chan_pins(mcr_a_d);
        pins_b_d = chan_pins(mcr_b_d);
        irq_a_d  = CHA_IRQ_REQ;
        irq_b_d  = CHB_IRQ_REQ;
        rx_d     = sync2_q.rx;
        status_d = sync2_q.modem;
        rts_n_d  = !mcr_b_d[uart_pin_pkg::RTS_BIT_POS];
        dtr_n_d  = !mcr_b_d[uart_pin_pkg::DTR_BIT_POS];
        if (dev_reset_d)
            tx_d = uart_pin_pkg::PIN_HIGH;
        else
            tx_d = CHB_SERIAL_TX;
    end

    // Status lines only reach the status port, never the line logic
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pins_a_q <= uart_pin_pkg::CHAN_PIN_RESET;
            pins_b_q <= uart_pin_pkg::CHAN_PIN_RESET;
            irq_a_q  <= uart_pin_pkg::PIN_LOW;
            irq_b_q  <= uart_pin_pkg::PIN_LOW;
            tx_q     <= uart_pin_pkg::PIN_HIGH;
            rx_q     <= uart_pin_pkg::PIN_HIGH;
            status_q <= uart_pin_pkg::STATUS_IDLE;
            rts_n_q  <= uart_pin_pkg::PIN_HIGH;
            dtr_n_q  <= uart_pin_pkg::PIN_HIGH;
        end else begin
            pins_a_q <= pins_a_d;
            pins_b_q <= pins_b_d;
            irq_a_q  <= irq_a_d;
            irq_b_q  <= irq_b_d;
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            status_q <= status_d;
            rts_n_q  <= rts_n_d;
            dtr_n_q  <= dtr_n_d;
        end
    end

    // Drive the ports from the flops
    assign CHA_PORT_OUT_N       = pins_a_q.port_n;
    assign CHA_IRQ_OE           = pins_a_q.irq_oe;
    assign CHB_PORT_OUT_N       = pins_b_q.port_n;
    assign CHB_IRQ_OE           = pins_b_q.irq_oe;
    assign CHA_IRQ_OUT          = irq_a_q;
    assign CHB_IRQ_OUT          = irq_b_q;
    assign CHB_SERIAL_OUT       = tx_q;
    assign CHB_SERIAL_RX        = rx_q;
    assign CHB_MODEM_STATUS     = status_q;
    assign CHB_REQUEST_SEND_N   = rts_n_q;
    assign CHB_TERMINAL_READY_N = dtr_n_q;
    assign DEV_RESET            = dev_reset_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_port_set;
        @(posedge CLOCK) disable iff (SYS_RST)
        (host_wr.wr && !host_wr.chan_b && !dev_reset_q
            && host_wr.data[uart_pin_pkg::PORT_BIT_POS]) |=> (!CHA_PORT_OUT_N && CHA_IRQ_OE);
    endproperty
    a_port_set: assert property (p_port_set)
        else $error("port bit set but pin or enable wrong");

    property p_port_clr;
        @(posedge CLOCK) disable iff (SYS_RST)
        (host_wr.wr && !host_wr.chan_b && !dev_reset_q
            && !host_wr.data[uart_pin_pkg::PORT_BIT_POS]) |=> (CHA_PORT_OUT_N && !CHA_IRQ_OE);
    endproperty
    a_port_clr: assert property (p_port_clr)
        else $error("port bit clear but pin or enable wrong");

    property p_strobe_style;
        @(posedge CLOCK) disable iff (SYS_RST)
        (bus_style == uart_pin_pkg::BUS_STROBES && sync2_q.wr_n) |-> !wr_start;
    endproperty
    a_strobe_style: assert property (p_strobe_style)
        else $error("write taken without write strobe");

    property p_dir_style;
        @(posedge CLOCK) disable iff (SYS_RST)
        (bus_style == uart_pin_pkg::BUS_DIR_CS && sync2_q.rw) |-> !wr_start;
    endproperty
    a_dir_style: assert property (p_dir_style)
        else $error("write taken while direction reads");

    property p_rts_dtr;
        @(posedge CLOCK) disable iff (SYS_RST)
        (CHB_REQUEST_SEND_N == !mcr_b_q[uart_pin_pkg::RTS_BIT_POS])
            && (CHB_TERMINAL_READY_N == !mcr_b_q[uart_pin_pkg::DTR_BIT_POS]);
    endproperty
    a_rts_dtr: assert property (p_rts_dtr)
        else $error("modem outputs not active low");

    property p_reset_pol;
        @(posedge CLOCK) disable iff (SYS_RST)
        1'h1 |=> (DEV_RESET == ($past(sync2_q.style) ? $past(sync2_q.rst_pin)
                                                     : !$past(sync2_q.rst_pin)));
    endproperty
    a_reset_pol: assert property (p_reset_pol)
        else $error("reset sense does not follow bus style");

    property p_chan_indep;
        @(posedge CLOCK) disable iff (SYS_RST)
        (host_wr.wr && !host_wr.chan_b && !dev_reset_q)
            |=> ($stable(CHB_PORT_OUT_N) && $stable(CHB_IRQ_OE));
    endproperty
    a_chan_indep: assert property (p_chan_indep)
        else $error("write to one channel moved the other");

    property p_tx_idle;
        @(posedge CLOCK) disable iff (SYS_RST)
        DEV_RESET |-> CHB_SERIAL_OUT;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("transmit line not idle in reset");

    // Main scenarios seen
    c_write_a: cover property (@(posedge CLOCK) host_wr.wr && !host_wr.chan_b);
    c_write_b: cover property (@(posedge CLOCK) host_wr.wr && host_wr.chan_b);
    c_dir_write: cover property (@(posedge CLOCK)
        host_wr.wr && bus_style == uart_pin_pkg::BUS_DIR_CS);
    c_dev_reset: cover property (@(posedge CLOCK) $rose(DEV_RESET));

endmodule : dual_uart_modem_pin_control

// file: uart_pin_pkg.sv
// Package of constants and carrier types for the dual UART pin control block
package uart_pin_pkg;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int         PORT_BIT_POS   = 3;
    localparam logic [7:0] MCR_RESET      = 8'h00;
    localparam logic       STYLE_STROBES  = 1'b1;
    localparam logic       STYLE_DIR_CS   = 1'b0;
    localparam logic [1:0] SYNC_RESET     = 2'b11;
    localparam int         RTS_BIT_POS    = 1; // Default spot, not fixed by the pin rules
    localparam int         DTR_BIT_POS    = 0; // Default spot, not fixed by the pin rules
    localparam logic       PIN_HIGH       = 1'h1;
    localparam logic       PIN_LOW        = 1'h0;
    localparam logic [3:0] STATUS_IDLE    = 4'hF;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        BUS_STROBES = 2'b01,
        BUS_DIR_CS  = 2'b10
    } bus_style_t;

    // Modem status inputs of one channel, active low, synchronised
    typedef struct packed {
        logic clear_send_n;
        logic set_ready_n;
        logic carrier_n;
        logic ring_n;
    } modem_in_t;

    // Host write strobes after the bus style decode
    typedef struct packed {
        logic       wr;
        logic       chan_b;
        logic [7:0] data;
    } host_wr_t;

    // All inputs from outside the clock domain, one word per stage
    typedef struct packed {
        logic       style;
        logic       rst_pin;
        logic       cs_n;
        logic       wr_n;
        logic       rw;
        logic       chan_b;
        logic       rx;
        modem_in_t  modem;
        logic [7:0] data;
    } pin_sync_t;

    // Pin state that one control register sets
    typedef struct packed {
        logic port_n;
        logic irq_oe;
    } chan_pin_t;

    // Idle bus and idle lines while reset is held
    localparam pin_sync_t PIN_SYNC_RESET = '{style: 1'h1, rst_pin: 1'h0, cs_n: 1'h1,
                                             wr_n: 1'h1, rw: 1'h1, chan_b: 1'h0,
                                             rx: 1'h1, modem: 4'hF, data: 8'h00};
    localparam chan_pin_t CHAN_PIN_RESET = '{port_n: 1'h1, irq_oe: 1'h0};

endpackage : uart_pin_pkg

// file: serial_peer.sv
// Serial peer model for channel B
`timescale 1ns/1ps
module serial_peer (
    input  wire logic       ring,
    output logic            rx_line,
    output logic [3:0]      status_n
);
    // Line idles high between characters
    assign rx_line  = 1'b1;
    // Ring indicator is the only status line the bench moves
    assign status_n = {3'b111, ~ring};
endmodule : serial_peer

// file: tb.sv
// Testbench for the modem and port pin control block
`timescale 1ns/1ps
module tb;
    logic       CLOCK = 0, SYS_RST = 1, sty = 1, pin = 0, cs_n = 1, ch = 0, wr_n = 1;
    logic       rw = 1, ring = 0, irq_a = 0, irq_b = 0, tx = 1;
    logic       rx, so, sr, rts, dtr, ia, ia_oe, ib, ib_oe, pa, pb, drst;
    logic [7:0] wd = 8'h00;
    logic [3:0] st, ms;
    int         fail_count = 0, compares = 0;
    serial_peer i_serial_peer (.ring(ring), .rx_line(rx), .status_n(st));
    dual_uart_modem_pin_control i_dual_uart_modem_pin_control (.CLOCK(CLOCK),
        .SYS_RST(SYS_RST), .BUS_STYLE(sty), .DEV_RESET_PIN(pin), .CS_N(cs_n), .CHAN_SEL(ch),
        .WR_STROBE_N(wr_n), .RW_DIR(rw), .WR_DATA(wd), .CHA_IRQ_REQ(irq_a), .CHB_IRQ_REQ(irq_b),
        .CHB_SERIAL_TX(tx), .CHB_SERIAL_IN(rx), .CHB_CLEAR_SEND_N(st[3]),
        .CHB_SET_READY_N(st[2]), .CHB_CARRIER_N(st[1]), .CHB_RING_N(st[0]),
        .CHB_SERIAL_OUT(so), .CHB_SERIAL_RX(sr), .CHB_REQUEST_SEND_N(rts),
        .CHB_TERMINAL_READY_N(dtr), .CHB_MODEM_STATUS(ms), .CHA_IRQ_OUT(ia),
        .CHA_IRQ_OE(ia_oe), .CHB_IRQ_OUT(ib), .CHB_IRQ_OE(ib_oe), .CHA_PORT_OUT_N(pa),
        .CHB_PORT_OUT_N(pb), .DEV_RESET(drst));
    // Clock at 100 ns period
    initial forever #50 CLOCK = ~CLOCK;
    task automatic check(input string nm, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, exp, got);
        end
    endtask : check
    // Let pins pass the synchronisers and the output flops
    task automatic settle;
        repeat (4) @(posedge CLOCK);
        #5;
    endtask : settle
    // One host cycle with chosen strobe and direction levels, held past the sampling
    task automatic wr(input logic b, input logic [7:0] d, input logic wn, input logic r);
        @(posedge CLOCK) #5 {ch, wd, cs_n, wr_n, rw} = {b, d, 1'b0, wn, r};
        repeat (3) @(posedge CLOCK);
        #5 {cs_n, wr_n, rw} = 3'b111;
        settle();
    endtask : wr
    // Port bit of A set and cleared, B must not move
    task automatic t_port;
        irq_a = 1;
        wr(0, 8'h08, 0, 1);
        check("a set", 2'b01, {pa, ia_oe});
        check("a irq", 2'b11, {ia, ia_oe});
        check("b idle", 2'b10, {pb, ib_oe});
        ring = 1;
        wr(0, 8'h00, 0, 1);
        check("a clr", 2'b10, {pa, ia_oe});
        check("ser out", 2'b11, {so, sr});
        check("status hi", 2'b11, ms[3:2]);
        check("status lo", 2'b10, ms[1:0]);
    endtask : t_port
    // Modem outputs of B, and strobe style ignores the direction line
    task automatic t_lines;
        wr(1, 8'h03, 0, 1);
        check("rts dtr", 2'b00, {rts, dtr});
        wr(1, 8'h08, 1, 0);
        check("strobe only", 2'b10, {pb, ib_oe});
        check("rts kept", 2'b00, {rts, dtr});
    endtask : t_lines
    // Direction plus select style, with inverted reset sense
    task automatic t_style;
        sty = 0;
        pin = 1;
        irq_b = 1;
        settle();
        wr(1, 8'h08, 0, 1);
        check("dir no strobe", 2'b10, {pb, ib_oe});
        wr(1, 8'h08, 1, 0);
        check("b set", 2'b01, {pb, ib_oe});
        check("b irq", 2'b11, {ib, ib_oe});
        check("a kept", 2'b10, {pa, ia_oe});
        check("rts dtr off", 2'b11, {rts, dtr});
        check("rst lo", 2'b00, {1'b0, drst});
        pin = 0;
        tx = 0;
        settle();
        check("rst hi", 2'b01, {1'b0, drst});
        check("tx held", 2'b01, {1'b0, so});
        check("b cleared", 2'b10, {pb, ib_oe});
        sty = 1;
        settle();
        check("rst s1", 2'b00, {1'b0, drst});
        check("tx free", 2'b00, {1'b0, so});
        tx = 1;
    endtask : t_style
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // Watchdog well past the under one hundred cycles needed
    initial begin
        #100000 fail_count++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge CLOCK);
        #5 SYS_RST = 0;
        t_port();
        t_lines();
        t_style();
        test_done();
    end
endmodule : tb
